// *** rtl/aux_watchdog_timeout_control.sv ***
// auxiliary watchdog: timeout counter, control/config registers, forced timeout sources
// assumes register strobes come from logic on clock; kbc line and reload events are
// asynchronous and are synchronised here
// Function
// [R1] control bit 0 reads 1 after a timeout, 0 while counting; writable
// [R2] writing 1 to control bit 2 forces a timeout; bit self-clears
// [R3] with bit 3 set, kbc line rising edge forces timeout; otherwise ignored
// [R4] force bit works regardless of kbc enable; sources are independent
// [R5] self-clearing rising edge detector on kbc line, ORed with force bit
// [R6] software writes zero to control bits 7:4; device treats them reserved
// [R7] control register clears to zero on standby power-on reset
// [R8] config bits 7:4 route interrupt: 0 off, 1, 3, 15; 2 invalid
// [R9] 8-bit binary timeout value; 0 disables, 1..255 time units
// [R10] unit bit 7: 0 minutes by default, 1 seconds
// [R11] game port, keyboard, mouse enables each let that source reload watchdog
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module aux_watchdog_timeout_control
    import wdt_pkg::*;
#(
    parameter longint SECOND_COUNT = SECOND_CYCLES
) (
    // clock and resets
    input  wire logic                   clock,
    input  wire logic                   resetn,
    input  wire logic                   standby_power_on_resetn,
    // register port
    input  wire logic [wdt_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [wdt_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                   reg_write,
    input  wire logic                   reg_read,
    output logic      [wdt_pkg::DATA_W-1:0] reg_rdata,
    // asynchronous event inputs
    input  wire logic                   kbc_timeout_line,
    input  wire logic                   game_port_access,
    input  wire logic                   keyboard_irq,
    input  wire logic                   mouse_irq,
    // outputs
    output logic                        irq_line1,
    output logic                        irq_line3,
    output logic                        irq_line15,
    output logic                        irq
);
    import wdt_pkg::*;

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [7:0]            unit_q;
    logic [7:0]            value_q;
    logic [7:0]            config_q;
    logic                  status_q;
    logic                  kbc_en_q;
    logic                  force_q;
    logic [EV_W-1:0]       int_status_q;
    logic [EV_W-1:0]       int_mask_q;
    logic [7:0]            rdata_d;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction

    logic wr_unit, wr_value, wr_config, wr_control, wr_istat, wr_imask;
    assign wr_unit    = reg_write && hit(reg_addr, UNIT_ADDR);
    assign wr_value   = reg_write && hit(reg_addr, VALUE_ADDR);
    assign wr_config  = reg_write && hit(reg_addr, CONFIG_ADDR);
    assign wr_control = reg_write && hit(reg_addr, CONTROL_ADDR);
    assign wr_istat   = reg_write && hit(reg_addr, INT_STATUS_ADDR);
    assign wr_imask   = reg_write && hit(reg_addr, INT_MASK_ADDR);

    // ----------------------------------------------------------------
    // configuration registers, on the ordinary reset
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            unit_q <= RESET_VALUE;
        end else begin
            if (wr_unit) begin
                unit_q <= reg_wdata & UNIT_WMASK;                    // [R10]
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            value_q <= RESET_VALUE;
        end else begin
            if (wr_value) begin
                value_q <= reg_wdata;                                // [R9]
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            config_q <= RESET_VALUE;
        end else begin
            if (wr_config) begin
                config_q <= reg_wdata & CONFIG_WMASK;                // [R8] [R11]
            end
        end
    end

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else begin
            sync1_q <= {mouse_irq, keyboard_irq, game_port_access, kbc_timeout_line};
            sync2_q <= sync1_q;
        end
    end

    // rising edge detectors: one-cycle pulses, so a kbc line held high forever
    // still forces a single timeout
    logic [3:0] prev_q;
    logic [3:0] rise;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            prev_q <= 4'h0;
        end else begin
            prev_q <= sync2_q;
        end
    end
    assign rise = sync2_q & ~prev_q;                                 // [R5]

    // ----------------------------------------------------------------
    // timeout triggers and reload sources
    // ----------------------------------------------------------------
    logic kbc_force;
    logic force_event;
    logic reload;
    assign kbc_force   = kbc_en_q && rise[0];                        // [R3]
    assign force_event = force_q || kbc_force;                       // [R4] [R5]
    assign reload      = (config_q[CFG_GAME_BIT]  && rise[1])
                      || (config_q[CFG_KBD_BIT]   && rise[2])
                      || (config_q[CFG_MOUSE_BIT] && rise[3]);       // [R11]

    // ----------------------------------------------------------------
    // timeout counter
    // ----------------------------------------------------------------
    logic [PRESCALE_W-1:0] pre_q;
    logic [TICK_W-1:0]     tick_q;
    logic [7:0]            units_q;
    logic                  sec_tick;
    logic                  unit_tick;
    logic                  expire;
    logic                  disabled;

    assign disabled  = value_q == TIMEOUT_OFF;                      // [R9]
    assign sec_tick  = pre_q == PRESCALE_W'(SECOND_COUNT - 1);
    assign unit_tick = sec_tick && (unit_q[UNIT_SEL_BIT]
                       || tick_q == MINUTE_TICKS - 6'h01);           // [R10]
    assign expire    = !disabled && !status_q && unit_tick
                       && units_q == value_q - 8'h01;

    logic                  restart;
    // counting restarts after a reload, a new value, or a cleared status
    assign restart   = disabled || status_q || reload || wr_value;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pre_q <= '0;
        end else if (restart) begin
            pre_q <= '0;
        end else begin
            pre_q <= sec_tick ? '0 : pre_q + PRESCALE_W'(1);
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tick_q <= '0;
        end else if (restart) begin
            tick_q <= '0;
        end else if (sec_tick) begin
            tick_q <= unit_tick ? '0 : tick_q + 6'h01;               // [R10]
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            units_q <= 8'h00;
        end else if (restart) begin
            units_q <= 8'h00;
        end else if (unit_tick) begin
            units_q <= units_q + 8'h01;                              // [R9]
        end
    end

    // ----------------------------------------------------------------
    // control register, on the standby reset
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge standby_power_on_resetn) begin
        if (!standby_power_on_resetn) begin
            force_q <= 1'b0;                                         // [R7]
        end else begin
            // force bit lives one cycle only
            force_q <= wr_control && reg_wdata[CTL_FORCE_BIT];       // [R2]
        end
    end

    always_ff @(posedge clock or negedge standby_power_on_resetn) begin
        if (!standby_power_on_resetn) begin
            kbc_en_q <= 1'b0;                                        // [R7]
        end else begin
            if (wr_control) begin
                kbc_en_q <= reg_wdata[CTL_KBC_EN_BIT];               // [R3]
            end
        end
    end

    always_ff @(posedge clock or negedge standby_power_on_resetn) begin
        if (!standby_power_on_resetn) begin
            status_q <= 1'b0;                                        // [R7]
        end else begin
            // a timeout in the write cycle wins over a software clear
            if (expire || force_event) begin
                status_q <= 1'b1;                                    // [R1]
            end else if (wr_control) begin
                status_q <= reg_wdata[CTL_STATUS_BIT];               // [R1]
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------------
    logic [EV_W-1:0] ev;
    assign ev = {kbc_force, force_q, expire || force_event};

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            int_status_q <= '0;
        end else begin
            int_status_q <= ev | (int_status_q
                            & ~(wr_istat ? reg_wdata[EV_W-1:0] : {EV_W{1'b0}}));
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            int_mask_q <= '0;
        end else begin
            if (wr_imask) begin
                int_mask_q <= reg_wdata[EV_W-1:0];
            end
        end
    end

    logic [3:0] route;
    assign route = config_q[CFG_IRQ_LSB +: 4];

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq_line1  <= 1'b0;
            irq_line3  <= 1'b0;
            irq_line15 <= 1'b0;
        end else begin
            // invalid routing code drives no line
            irq_line1  <= status_q && route == IRQ_LINE1;            // [R8]
            irq_line3  <= status_q && route == IRQ_LINE3;            // [R8]
            irq_line15 <= status_q && route == IRQ_LINE15;           // [R8]
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_status_q & int_mask_q);
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    always_comb begin
        rdata_d = 8'h00;
        case (reg_addr)
            UNIT_ADDR:       rdata_d = unit_q;
            VALUE_ADDR:      rdata_d = value_q;
            CONFIG_ADDR:     rdata_d = config_q;
            // force bit is write-only, reserved bits read zero
            CONTROL_ADDR:    rdata_d = {4'h0, kbc_en_q, 2'b00, status_q}
                                       & CONTROL_RMASK;              // [R6]
            INT_STATUS_ADDR: rdata_d = {5'h00, int_status_q};
            INT_MASK_ADDR:   rdata_d = {5'h00, int_mask_q};
            default:         rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_read ? rdata_d : 8'h00;
        end
    end
endmodule

// *** rtl/wdt_pkg.sv ***
// constants for the auxiliary watchdog timeout control block
// assumes a 200 MHz clock and an 8-bit register port with byte indices as addresses
package wdt_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    // register indices, used directly as port addresses
    localparam logic [7:0]  UNIT_ADDR       = 8'hF1;
    localparam logic [7:0]  VALUE_ADDR      = 8'hF2;
    localparam logic [7:0]  CONFIG_ADDR     = 8'hF3;
    localparam logic [7:0]  CONTROL_ADDR    = 8'hF4;
    localparam logic [7:0]  INT_STATUS_ADDR = 8'hF5;
    localparam logic [7:0]  INT_MASK_ADDR   = 8'hF6;
    localparam logic [7:0]  RESET_VALUE     = 8'h00;
    localparam logic [7:0]  UNIT_WMASK      = 8'h80;
    localparam logic [7:0]  CONFIG_WMASK    = 8'hF7;
    localparam logic [7:0]  CONTROL_RMASK   = 8'h09;
    // control fields
    localparam int          CTL_STATUS_BIT  = 0;
    localparam int          CTL_FORCE_BIT   = 2;
    localparam int          CTL_KBC_EN_BIT  = 3;
    // config fields
    localparam int          CFG_GAME_BIT    = 0;
    localparam int          CFG_KBD_BIT     = 1;
    localparam int          CFG_MOUSE_BIT   = 2;
    localparam int          CFG_IRQ_LSB     = 4;
    localparam int          UNIT_SEL_BIT    = 7;
    // interrupt routing codes
    localparam logic [3:0]  IRQ_OFF         = 4'h0;
    localparam logic [3:0]  IRQ_LINE1       = 4'h1;
    localparam logic [3:0]  IRQ_BAD         = 4'h2;
    localparam logic [3:0]  IRQ_LINE3       = 4'h3;
    localparam logic [3:0]  IRQ_LINE15      = 4'hF;
    localparam logic [7:0]  TIMEOUT_OFF     = 8'h00;
    // interrupt status/mask bits
    localparam int          EV_TIMEOUT_BIT  = 0;
    localparam int          EV_FORCE_BIT    = 1;
    localparam int          EV_KBC_BIT      = 2;
    localparam int          EV_W            = 3;
    // time base
    localparam longint      CLOCK_HZ        = 200_000_000;
    localparam longint      SECOND_S        = 1;
    localparam longint      MINUTE_S        = 60;
    localparam longint      SECOND_CYCLES   = CLOCK_HZ * SECOND_S;
    localparam int          PRESCALE_W      = 32;
    localparam int          TICK_W          = 6;
    localparam logic [5:0]  MINUTE_TICKS    = 6'(MINUTE_S);
endpackage

// *** test/aux_wdt_assertions.sv ***
// port-level assertions for the auxiliary watchdog timeout control
// assumes one clock and register strobes one cycle long
`timescale 1ns/1ps
module aux_wdt_checker
    import wdt_pkg::*;
(
    // clock and resets
    input wire logic                       clock,
    input wire logic                       resetn,
    input wire logic                       standby_power_on_resetn,
    // register port
    input wire logic [wdt_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [wdt_pkg::DATA_W-1:0] reg_wdata,
    input wire logic                       reg_write,
    input wire logic                       reg_read,
    input wire logic [wdt_pkg::DATA_W-1:0] reg_rdata,
    // interrupt outputs
    input wire logic                       irq_line1,
    input wire logic                       irq_line3,
    input wire logic                       irq_line15,
    input wire logic                       irq
);
    // ------------------------------------------------------------
    // sequences and properties
    // ------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn || !standby_power_on_resetn);
    sequence s_wr(a);
        reg_write && reg_addr == a;
    endsequence
    sequence s_rd(a);
        reg_read && !reg_write && reg_addr == a;
    endsequence
    sequence s_force;
        s_wr(CONTROL_ADDR) ##0 reg_wdata[CTL_FORCE_BIT];
    endsequence
    property p_back(a, m);
        s_wr(a) ##1 s_rd(a) |=> reg_rdata == ($past(reg_wdata, 2) & m);
    endproperty
    a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read slot");
    a_unmapped_zero: assert property (reg_read && (reg_addr < UNIT_ADDR ||
        reg_addr > INT_MASK_ADDR) |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_ctrl_reserved: assert property (s_rd(CONTROL_ADDR) |=>
        (reg_rdata & ~CONTROL_RMASK) == 8'h00) else $error("control reserved or force bit set");
    a_force_status: assert property (s_force ##3 s_rd(CONTROL_ADDR) |=>
        reg_rdata[CTL_STATUS_BIT]) else $error("force did not set status");
    a_value_back: assert property (p_back(VALUE_ADDR, 8'hFF))
        else $error("timeout value readback wrong");
    a_config_back: assert property (p_back(CONFIG_ADDR, CONFIG_WMASK))
        else $error("config readback wrong");
    a_unit_back: assert property (p_back(UNIT_ADDR, UNIT_WMASK))
        else $error("unit readback wrong");
    a_kbc_en_back: assert property (s_wr(CONTROL_ADDR) ##1 s_rd(CONTROL_ADDR) |=>
        (reg_rdata & 8'h08) == ($past(reg_wdata, 2) & 8'h08)) else $error("kbc enable lost");
    a_route_onehot: assert property ($onehot0({irq_line1, irq_line3, irq_line15}))
        else $error("more than one irq line");
    a_reset_quiet: assert property ($rose(resetn) |-> !irq && !irq_line1 &&
        !irq_line3 && !irq_line15) else $error("irq active after reset");
endmodule

bind aux_watchdog_timeout_control aux_wdt_checker aux_wdt_checker_i (.*);

// *** test/test_aux_watchdog_timeout_control.sv ***
// self-checking bench for the auxiliary watchdog timeout control
// assumes a second of SEC cycles so that timeouts stay short
`timescale 1ns/1ps
module test_aux_watchdog_timeout_control;
    import wdt_pkg::*;
    localparam longint SEC = 10;
    logic       clock = 1'b0;
    logic       resetn = 1'b0;
    logic       standby_power_on_resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_write = 1'b0;
    logic       reg_read = 1'b0;
    logic [3:0] src = 4'h0;
    logic [7:0] reg_rdata;
    logic       irq_line1, irq_line3, irq_line15, irq;
    int         n_mismatch = 0;
    int         samples_checked = 0;
    // address, write data, read back
    logic [23:0] rows [6] = '{24'hF1FF80, 24'hF2A5A5, 24'hF3FFF7, 24'hF40808, 24'hF60707,
        24'hF0FF00};
    // route code, then {irq, line15, line3, line1}
    logic [7:0] routes [5] = '{8'h08, 8'h19, 8'h28, 8'h3A, 8'hFC};

    aux_watchdog_timeout_control #(.SECOND_COUNT(SEC)) aux_watchdog_timeout_control_i (.*,
        .kbc_timeout_line(src[0]), .game_port_access(src[1]), .keyboard_irq(src[2]),
        .mouse_irq(src[3]));

    always #2.5 clock = ~clock;

    // ------------------------------------------------------------
    // bus tasks, entered just after a rising edge
    // ------------------------------------------------------------
    task check(input string n, input logic [7:0] s, input logic [7:0] e);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    // a write leaves its strobe up; the next task lowers it once
    task idle(input int n);
        reg_write <= 1'b0;
        repeat (n) @(posedge clock);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        reg_write <= 1'b0;
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 check($sformatf("reg %h", a), reg_rdata, e);
        @(posedge clock);
    endtask
    task outs(input logic [7:0] e);
        reg_write <= 1'b0;
        #1 check("irq outputs", {4'h0, irq, irq_line15, irq_line3, irq_line1}, e);
        @(posedge clock);
    endtask
    // one pulse of a reload or kbc source, long enough to pass the synchroniser
    task pulse(input int k);
        src[k] <= 1'b1;
        idle(3);
        src[k] <= 1'b0;
        idle(5);
    endtask
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #100000;
        n_mismatch++;
        report_and_stop;
    end

    initial begin
        idle(20);
        resetn <= 1'b1;
        standby_power_on_resetn <= 1'b1;
        idle(1);
        for (int a = 8'hF0; a <= 8'hF6; a++)
            rd(8'(a), 8'h00);
        for (int i = 0; i < 6; i++) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rows[i][7:0]);
        end
        wr(VALUE_ADDR, 8'h00);
        wr(CONTROL_ADDR, 8'h00);
        wr(CONTROL_ADDR, 8'h04);
        idle(2);
        rd(CONTROL_ADDR, 8'h01);
        for (int i = 0; i < 5; i++) begin
            wr(CONFIG_ADDR, {routes[i][7:4], 4'h0});
            idle(2);
            outs({4'h0, routes[i][3:0]});
        end
        rd(INT_STATUS_ADDR, 8'h03);
        wr(INT_MASK_ADDR, 8'h00);
        idle(2);
        outs(8'h04);
        wr(INT_STATUS_ADDR, 8'h03);
        rd(INT_STATUS_ADDR, 8'h00);
        wr(INT_MASK_ADDR, 8'h07);
        wr(CONTROL_ADDR, 8'h00);
        rd(CONTROL_ADDR, 8'h00);
        // kbc line ignored, then honoured on its edge only
        src[0] <= 1'b1;
        idle(8);
        rd(CONTROL_ADDR, 8'h00);
        src[0] <= 1'b0;
        wr(CONTROL_ADDR, 8'h08);
        idle(2);
        src[0] <= 1'b1;
        idle(8);
        rd(CONTROL_ADDR, 8'h09);
        rd(INT_STATUS_ADDR, 8'h05);
        outs(8'h0C);
        wr(CONTROL_ADDR, 8'h08);
        idle(8);
        rd(CONTROL_ADDR, 8'h08);
        wr(CONTROL_ADDR, 8'h0C);
        idle(2);
        rd(CONTROL_ADDR, 8'h09);
        src[0] <= 1'b0;
        wr(INT_STATUS_ADDR, 8'h07);
        idle(2);
        outs(8'h04);
        // two seconds of SEC cycles each
        wr(UNIT_ADDR, 8'h80);
        wr(CONTROL_ADDR, 8'h00);
        wr(VALUE_ADDR, 8'h02);
        idle(8);
        rd(CONTROL_ADDR, 8'h00);
        idle(30);
        rd(CONTROL_ADDR, 8'h01);
        for (int s = 0; s < 3; s++) begin
            wr(CONFIG_ADDR, 8'(1 << s));
            wr(CONTROL_ADDR, 8'h00);
            repeat (6) pulse(s + 1);
            rd(CONTROL_ADDR, 8'h00);
            repeat (6) pulse((s + 1) % 3 + 1);
            rd(CONTROL_ADDR, 8'h01);
        end
        wr(VALUE_ADDR, 8'h00);
        wr(CONTROL_ADDR, 8'h00);
        idle(40);
        rd(CONTROL_ADDR, 8'h00);
        wr(UNIT_ADDR, 8'h00);
        wr(VALUE_ADDR, 8'h01);
        wr(CONTROL_ADDR, 8'h00);
        idle(500);
        rd(CONTROL_ADDR, 8'h00);
        idle(200);
        rd(CONTROL_ADDR, 8'h01);
        // ordinary reset keeps control, standby reset clears it
        wr(CONTROL_ADDR, 8'h08);
        resetn <= 1'b0;
        idle(2);
        resetn <= 1'b1;
        idle(1);
        rd(CONTROL_ADDR, 8'h08);
        rd(VALUE_ADDR, 8'h00);
        standby_power_on_resetn <= 1'b0;
        idle(2);
        standby_power_on_resetn <= 1'b1;
        idle(1);
        rd(CONTROL_ADDR, 8'h00);
        report_and_stop;
    end
endmodule
